// file: logic/dap_chan.sv
// Purpose: One channel: range clamp, fixed latency pipeline, output format
// Assumes: ctl.tick is a one-cycle sample enable, at least two cycles apart
// Notes: Pipeline empties on sleep, so a wake costs a full latency
`timescale 1ns/1ps
`default_nettype none
module dap_chan (
    input wire logic sys_clk,
    input wire logic rst_n,
    dap_ctl_if.chan ctl,
    input wire logic [dap_pkg::RAW_W-1:0] raw,
    output logic [dap_pkg::SAMPLE_W-1:0] word,
    output logic over,
    output logic load
);
    typedef struct packed {
        logic [dap_pkg::LATENCY-1:0][dap_pkg::SAMPLE_W:0] pipe;
        logic [dap_pkg::LATENCY-1:0] vld;
        logic [dap_pkg::SAMPLE_W-1:0] word;
        logic over;
        logic load;
    } dap_chan_st_t;

    dap_chan_st_t st_ff;
    dap_chan_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.load = 1'b0;
        if (ctl.sleep) begin
            nxt_st.vld = '0;
        end else if (ctl.tick) begin
            nxt_st.pipe = {st_ff.pipe[dap_pkg::LATENCY-2:0], dap_pkg::sat_word(raw)};
            nxt_st.vld = {st_ff.vld[dap_pkg::LATENCY-2:0], 1'b1};
            if (st_ff.vld[dap_pkg::LATENCY-1]) begin
                // Format pin read at output time, it is static anyway
                nxt_st.word = ctl.gray_sel ? dap_pkg::to_gray(st_ff.pipe[dap_pkg::LATENCY-1][dap_pkg::SAMPLE_W-1:0])
                    : st_ff.pipe[dap_pkg::LATENCY-1][dap_pkg::SAMPLE_W-1:0];
                nxt_st.over = st_ff.pipe[dap_pkg::LATENCY-1][dap_pkg::SAMPLE_W];
                nxt_st.load = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign word = st_ff.word;
    assign over = st_ff.over;
    assign load = st_ff.load;
endmodule
`default_nettype wire

// file: logic/dap_ctl_if.sv
// Purpose: Control fan-out from the top to the channel and strobe modules
// Assumes: All members change on sys_clk only
// Notes: Top drives every member
`timescale 1ns/1ps
`default_nettype none
interface dap_ctl_if;
    logic tick;
    logic sleep;
    logic gray_sel;
    logic load;
    modport ctl(output tick, output sleep, output gray_sel, output load);
    modport chan(input tick, input sleep, input gray_sel);
    modport strb(input sleep, input load);
endinterface
`default_nettype wire

// file: logic/dap_pkg.sv
// Purpose: Shared constants, field layout and helpers of the dual converter output port
// Assumes: One 250 MHz clock; raw quantizer words arrive as 14-bit signed values
// Notes: Offsets are byte addresses on the plain register port
package dap_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int unsigned SAMPLE_W = 12;
    localparam int unsigned RAW_W = 14;
    localparam int unsigned LATENCY = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned EV_W = 3;
    localparam logic [7:0] DIV_MIN = 8'h02;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_CLR = 8'h0c;
    localparam logic [7:0] REG_IEN = 8'h10;
    localparam logic [7:0] REG_LIVE = 8'h14;
    localparam logic [7:0] REG_COUNT = 8'h18;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned EV_OVR_A_BIT = 0;
    localparam int unsigned EV_OVR_B_BIT = 1;
    localparam int unsigned EV_HALT_BIT = 2;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [7:0] DIV_RST = 8'h04;
    localparam logic [2:0] IEN_RST = 3'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clamp to 12-bit two's complement; bit 12 flags over-range
    function automatic logic [SAMPLE_W:0] sat_word(input logic [RAW_W-1:0] raw);
        logic [SAMPLE_W:0] res;
        res = {1'b0, raw[SAMPLE_W-1:0]};
        if (!raw[RAW_W-1] && (raw[RAW_W-2:SAMPLE_W-1] != 2'h0)) begin
            res = {1'b1, 12'h7ff};
        end else if (raw[RAW_W-1] && (raw[RAW_W-2:SAMPLE_W-1] != 2'h3)) begin
            res = {1'b1, 12'h800};
        end
        return res;
    endfunction

    function automatic logic [SAMPLE_W-1:0] to_gray(input logic [SAMPLE_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

endpackage

// file: logic/dap_strobe.sv
// Purpose: Data-valid strobe with its rising edge one cycle after new data
// Assumes: Loads are at least two cycles apart
// Notes: Held low from the second cycle of sleep on
`timescale 1ns/1ps
`default_nettype none
module dap_strobe (
    input wire logic sys_clk,
    input wire logic rst_n,
    dap_ctl_if.strb ctl,
    output logic strobe
);
    typedef enum logic [2:0] {
        STB_OFF = 3'b001,
        STB_LOW = 3'b010,
        STB_HIGH = 3'b100
    } dap_stb_state_t;

    typedef struct packed {
        dap_stb_state_t state;
    } dap_stb_st_t;

    dap_stb_st_t st_ff;
    dap_stb_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (ctl.sleep) begin
            nxt_st.state = STB_OFF;
        end else begin
            unique case (st_ff.state)
                STB_OFF: begin
                    nxt_st.state = ctl.load ? STB_HIGH : STB_LOW;
                end
                STB_LOW: begin
                    if (ctl.load) begin
                        nxt_st.state = STB_HIGH;
                    end
                end
                STB_HIGH: begin
                    nxt_st.state = STB_HIGH;
                end
                default: begin
                    nxt_st.state = STB_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{state: STB_OFF};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Masked in the load cycle, so each new word gives a fresh rising edge
    assign strobe = (st_ff.state == STB_HIGH) && !ctl.load;
endmodule
`default_nettype wire

// file: logic/dap_top.sv
// Purpose: Parallel output port of a dual 12-bit converter with its register file
// Assumes: Raw inputs and pins synchronous to sys_clk; sample rate from an internal divider
// Notes: Registers on a plain port with read data one cycle after the strobe
//
// Notes on behaviour
// - Channel B word, bit 0 LSB, bit 11 MSB
// - Channel A word, bit 0 LSB, bit 11 MSB
// - Channel B flag high beyond full scale
// - Channel A flag high beyond full scale
// - Strobe rising edge marks new data
// - Format pin low twos complement, high Gray
// - Sleep pin high powers both converters down
// - Output eight sample cycles after sampling
`timescale 1ns/1ps
`default_nettype none
module dap_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [dap_pkg::RAW_W-1:0] cha_raw,
    input wire logic [dap_pkg::RAW_W-1:0] chb_raw,
    input wire logic format_gray_sel,
    input wire logic sleep_request,
    input wire logic [dap_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dap_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dap_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    output logic sample_valid_strobe,
    output logic cha_over_range,
    output logic chb_over_range,
    output logic cha_bit0,
    output logic cha_bit1,
    output logic cha_bit2,
    output logic cha_bit3,
    output logic cha_bit4,
    output logic cha_bit5,
    output logic cha_bit6,
    output logic cha_bit7,
    output logic cha_bit8,
    output logic cha_bit9,
    output logic cha_bit10,
    output logic cha_bit11,
    output logic chb_bit0,
    output logic chb_bit1,
    output logic chb_bit2,
    output logic chb_bit3,
    output logic chb_bit4,
    output logic chb_bit5,
    output logic chb_bit6,
    output logic chb_bit7,
    output logic chb_bit8,
    output logic chb_bit9,
    output logic chb_bit10,
    output logic chb_bit11
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic [7:0] div;
        logic [7:0] div_cnt;
        logic [dap_pkg::EV_W-1:0] stat;
        logic [dap_pkg::EV_W-1:0] ien;
        logic [15:0] count;
        logic halt_d;
        logic [dap_pkg::DATA_W-1:0] rdata;
    } dap_top_st_t;

    dap_top_st_t st_ff;
    dap_top_st_t nxt_st;

    logic halted;
    logic tick;
    logic [7:0] div_eff;
    logic [dap_pkg::EV_W-1:0] ev;
    logic [dap_pkg::SAMPLE_W-1:0] a_word;
    logic [dap_pkg::SAMPLE_W-1:0] b_word;
    logic a_over;
    logic b_over;
    logic a_load;
    logic b_load;
    logic strobe;

    dap_ctl_if ctl ();

    // ------------------------------------------------------------
    // Sample rate and power state
    // ------------------------------------------------------------
    // Software stop shares the pin's effect, so a host can park the port
    assign halted = sleep_request | ~st_ff.run;
    // Below two cycles the strobe could not rise between samples
    assign div_eff = (st_ff.div < dap_pkg::DIV_MIN) ? dap_pkg::DIV_MIN : st_ff.div;
    assign tick = ~halted && (st_ff.div_cnt == div_eff - 8'h01);

    assign ctl.tick = tick;
    assign ctl.sleep = halted;
    assign ctl.gray_sel = format_gray_sel;
    assign ctl.load = a_load;

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[dap_pkg::EV_OVR_A_BIT] = a_load & a_over;
        ev[dap_pkg::EV_OVR_B_BIT] = b_load & b_over;
        ev[dap_pkg::EV_HALT_BIT] = halted & ~st_ff.halt_d;
    end

    // ------------------------------------------------------------
    // Next state and register port
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.halt_d = halted;
        if (halted || tick) begin
            nxt_st.div_cnt = 8'h00;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
        end
        if (a_load) begin
            nxt_st.count = st_ff.count + 16'h0001;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                dap_pkg::REG_CTRL: begin
                    nxt_st.run = reg_wdata[dap_pkg::CTRL_RUN_BIT];
                end
                dap_pkg::REG_DIV: begin
                    nxt_st.div = reg_wdata[7:0];
                end
                dap_pkg::REG_IEN: begin
                    nxt_st.ien = reg_wdata[dap_pkg::EV_W-1:0];
                end
                dap_pkg::REG_COUNT: begin
                    nxt_st.count = dap_pkg::COUNT_RST;
                end
                default: begin
                end
            endcase
        end
        // A new event in the clearing cycle stays set
        if (reg_wr && (reg_addr == dap_pkg::REG_CLR)) begin
            nxt_st.stat = (st_ff.stat & ~reg_wdata[dap_pkg::EV_W-1:0]) | ev;
        end else begin
            nxt_st.stat = st_ff.stat | ev;
        end
        nxt_st.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                dap_pkg::REG_CTRL: begin
                    nxt_st.rdata[dap_pkg::CTRL_RUN_BIT] = st_ff.run;
                end
                dap_pkg::REG_DIV: begin
                    nxt_st.rdata[7:0] = st_ff.div;
                end
                dap_pkg::REG_STAT: begin
                    nxt_st.rdata[dap_pkg::EV_W-1:0] = st_ff.stat;
                end
                dap_pkg::REG_IEN: begin
                    nxt_st.rdata[dap_pkg::EV_W-1:0] = st_ff.ien;
                end
                dap_pkg::REG_LIVE: begin
                    nxt_st.rdata[5:0] = {b_over, a_over, strobe, format_gray_sel, sleep_request, halted};
                end
                dap_pkg::REG_COUNT: begin
                    nxt_st.rdata[15:0] = st_ff.count;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{run: dap_pkg::CTRL_RUN_RST, div: dap_pkg::DIV_RST, div_cnt: 8'h00,
                       stat: '0, ien: dap_pkg::IEN_RST, count: dap_pkg::COUNT_RST,
                       halt_d: 1'b0, rdata: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Channels and strobe
    // ------------------------------------------------------------
    dap_chan u_cha (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ctl(ctl),
        .raw(cha_raw),
        .word(a_word),
        .over(a_over),
        .load(a_load)
    );

    dap_chan u_chb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ctl(ctl),
        .raw(chb_raw),
        .word(b_word),
        .over(b_over),
        .load(b_load)
    );

    // Both channels share tick and sleep, so one load marks both words
    dap_strobe u_stb (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ctl(ctl),
        .strobe(strobe)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_ff.rdata;
    assign irq = |(st_ff.stat & st_ff.ien);
    assign sample_valid_strobe = strobe;
    assign cha_over_range = a_over;
    assign chb_over_range = b_over;

    assign cha_bit0 = a_word[0];
    assign cha_bit1 = a_word[1];
    assign cha_bit2 = a_word[2];
    assign cha_bit3 = a_word[3];
    assign cha_bit4 = a_word[4];
    assign cha_bit5 = a_word[5];
    assign cha_bit6 = a_word[6];
    assign cha_bit7 = a_word[7];
    assign cha_bit8 = a_word[8];
    assign cha_bit9 = a_word[9];
    assign cha_bit10 = a_word[10];
    assign cha_bit11 = a_word[11];

    assign chb_bit0 = b_word[0];
    assign chb_bit1 = b_word[1];
    assign chb_bit2 = b_word[2];
    assign chb_bit3 = b_word[3];
    assign chb_bit4 = b_word[4];
    assign chb_bit5 = b_word[5];
    assign chb_bit6 = b_word[6];
    assign chb_bit7 = b_word[7];
    assign chb_bit8 = b_word[8];
    assign chb_bit9 = b_word[9];
    assign chb_bit10 = b_word[10];
    assign chb_bit11 = b_word[11];

endmodule
`default_nettype wire

// file: test/dap_backend_model.sv
// Purpose: Back-end capture logic that latches both channels on the strobe
// Assumes: Strobe, words and flags synchronous to sys_clk
// Notes: Capture counter lets the bench see missing or extra strobes
`timescale 1ns/1ps
`default_nettype none
module dap_backend_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic [dap_pkg::SAMPLE_W-1:0] word_a,
    input wire logic [dap_pkg::SAMPLE_W-1:0] word_b,
    input wire logic over_a,
    input wire logic over_b,
    output logic [dap_pkg::SAMPLE_W:0] cap_a,
    output logic [dap_pkg::SAMPLE_W:0] cap_b,
    output int cap_cnt
);
    logic strobe_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b0;
            cap_a <= '0;
            cap_b <= '0;
            cap_cnt <= 0;
        end else begin
            strobe_q <= strobe;
            // Latch on the rising edge only, words are settled by then
            if (strobe && !strobe_q) begin
                cap_a <= {over_a, word_a};
                cap_b <= {over_b, word_b};
                cap_cnt <= cap_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/dap_port_asserts.sv
// Purpose: Concurrent checks on the output port pins of dap_top
// Assumes: Bound to dap_top, sees its ports only
// Notes: Run-bit halts are not used by the bench; only the sleep pin halts
`timescale 1ns/1ps
`default_nettype none
module dap_port_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep_request,
    input wire logic sample_valid_strobe,
    input wire logic cha_over_range,
    input wire logic chb_over_range,
    input wire logic cha_bit0, cha_bit1, cha_bit2, cha_bit3, cha_bit4, cha_bit5,
    input wire logic cha_bit6, cha_bit7, cha_bit8, cha_bit9, cha_bit10, cha_bit11,
    input wire logic chb_bit0, chb_bit1, chb_bit2, chb_bit3, chb_bit4, chb_bit5,
    input wire logic chb_bit6, chb_bit7, chb_bit8, chb_bit9, chb_bit10, chb_bit11
);
    logic [11:0] wa;
    logic [11:0] wb;
    assign wa = {cha_bit11, cha_bit10, cha_bit9, cha_bit8, cha_bit7, cha_bit6,
                 cha_bit5, cha_bit4, cha_bit3, cha_bit2, cha_bit1, cha_bit0};
    assign wb = {chb_bit11, chb_bit10, chb_bit9, chb_bit8, chb_bit7, chb_bit6,
                 chb_bit5, chb_bit4, chb_bit3, chb_bit2, chb_bit1, chb_bit0};

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence load_s;
        !$stable({wa, wb, cha_over_range, chb_over_range});
    endsequence
    // Past reset term masks the async drop of a mid-run reset
    sequence recover_s;
        $fell(sample_valid_strobe) && !sleep_request && $past(rst_n) ##1 !sleep_request;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    words_held_a: assert property (sample_valid_strobe |-> $stable({wa, wb, cha_over_range, chb_over_range}))
        else $error("Outputs moved while strobe high");
    load_low_a: assert property (load_s |-> !sample_valid_strobe)
        else $error("Strobe high in cycle of new data");
    strobe_back_a: assert property (recover_s |-> sample_valid_strobe)
        else $error("Strobe did not rise one cycle after load");
    over_a_a: assert property (cha_over_range |-> wa inside {12'h7ff, 12'h800, 12'h400, 12'hc00})
        else $error("Channel A flag without full-scale word");
    over_b_a: assert property (chb_over_range |-> wb inside {12'h7ff, 12'h800, 12'h400, 12'hc00})
        else $error("Channel B flag without full-scale word");
    flag_align_a: assert property ($changed(cha_over_range) || $changed(chb_over_range) |-> !sample_valid_strobe)
        else $error("Flag changed outside a load");
    sleep_low_a: assert property (sleep_request [*4] |-> !sample_valid_strobe)
        else $error("Strobe high while asleep");
    sleep_hold_a: assert property (sleep_request [*4] |-> $stable({wa, wb}))
        else $error("Words moved while asleep");
    wake_gap_a: assert property ($fell(sleep_request) |-> !sample_valid_strobe [*8])
        else $error("Data before pipeline refilled");
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for dap_top
// Assumes: Raw inputs held steady for many ticks so captures are predictable
// Notes: Register port driven by the bench tasks below
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] cha_raw = '0;
    logic [13:0] chb_raw = '0;
    logic format_gray_sel = 1'b0;
    logic sleep_request = 1'b0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, sample_valid_strobe, cha_over_range, chb_over_range;
    logic cha_bit0, cha_bit1, cha_bit2, cha_bit3, cha_bit4, cha_bit5;
    logic cha_bit6, cha_bit7, cha_bit8, cha_bit9, cha_bit10, cha_bit11;
    logic chb_bit0, chb_bit1, chb_bit2, chb_bit3, chb_bit4, chb_bit5;
    logic chb_bit6, chb_bit7, chb_bit8, chb_bit9, chb_bit10, chb_bit11;
    logic [12:0] cap_a, cap_b;
    int cap_cnt;
    int n_fail = 0;
    int n_tests = 0;
    int div_eff = 4;
    logic [31:0] d;
    logic [13:0] t_a [4] = '{14'h0123, 14'h0800, 14'h07ff, 14'h0123};
    logic [13:0] t_b [4] = '{14'h3ffb, 14'h37ff, 14'h3800, 14'h3ffb};
    logic [12:0] e_a [4] = '{13'h0123, 13'h17ff, 13'h07ff, 13'h0123};
    logic [12:0] e_b [4] = '{13'h0ffb, 13'h1800, 13'h0800, 13'h0ffb};
    logic t_g [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    always #2 sys_clk = ~sys_clk;

    dap_top dap_top_inst (.*);
    dap_backend_model dap_backend_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .strobe(sample_valid_strobe),
        .word_a({cha_bit11, cha_bit10, cha_bit9, cha_bit8, cha_bit7, cha_bit6,
                 cha_bit5, cha_bit4, cha_bit3, cha_bit2, cha_bit1, cha_bit0}),
        .word_b({chb_bit11, chb_bit10, chb_bit9, chb_bit8, chb_bit7, chb_bit6,
                 chb_bit5, chb_bit4, chb_bit3, chb_bit2, chb_bit1, chb_bit0}),
        .over_a(cha_over_range), .over_b(chb_over_range), .cap_a(cap_a), .cap_b(cap_b), .cap_cnt(cap_cnt));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic drive(input logic [13:0] a, input logic [13:0] b, input logic g, input logic s);
        @(posedge sys_clk);
        cha_raw <= a;
        chb_raw <= b;
        format_gray_sel <= g;
        sleep_request <= s;
    endtask

    task automatic wait_ticks(input int n);
        repeat (n * div_eff) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [12:0] fmt(input logic [12:0] e, input logic g);
        return g ? {e[12], e[11:0] ^ {1'b0, e[11:1]}} : e;
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence of tests
    // ------------------------------------------------------------
    initial begin
        int cyc;
        int n0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(dap_pkg::REG_CTRL, d); check(d, 32'h1);
        rd(dap_pkg::REG_DIV, d); check(d, 32'h4);
        rd(dap_pkg::REG_STAT, d); check(d, 32'h0);
        rd(dap_pkg::REG_IEN, d); check(d, 32'h0);
        rd(8'h1c, d); check(d, 32'h0);
        wr(dap_pkg::REG_IEN, 32'h3);
        // Full-scale boundaries, both polarities, then the Gray format
        for (int i = 0; i < 4; i++) begin
            drive(t_a[i], t_b[i], t_g[i], 1'b0);
            wait_ticks(11);
            check(32'(cap_a), 32'(fmt(e_a[i], t_g[i])));
            check(32'(cap_b), 32'(fmt(e_b[i], t_g[i])));
        end
        check(32'(irq), 32'h1);
        rd(dap_pkg::REG_STAT, d); check(d, 32'h3);
        wr(dap_pkg::REG_IEN, 32'h0);
        #1 check(32'(irq), 32'h0);
        wr(dap_pkg::REG_CLR, 32'h7);
        rd(dap_pkg::REG_STAT, d); check(d, 32'h0);
        // Shortest divider, then sleep and wake
        wr(dap_pkg::REG_DIV, 32'h1);
        div_eff = 2;
        drive(14'h0123, 14'h3ffb, 1'b1, 1'b1);
        repeat (10) @(posedge sys_clk);
        #1 n0 = cap_cnt;
        check(32'(sample_valid_strobe), 32'h0);
        rd(dap_pkg::REG_STAT, d); check(d, 32'h4);
        rd(dap_pkg::REG_LIVE, d);
        check(d, 32'h7);
        wr(dap_pkg::REG_COUNT, 32'h0);
        rd(dap_pkg::REG_COUNT, d);
        check(d, 32'h0);
        drive(14'h0123, 14'h3ffb, 1'b1, 1'b1);
        repeat (20) @(posedge sys_clk);
        check(32'(cap_cnt), 32'(n0));
        drive(14'h0123, 14'h3ffb, 1'b1, 1'b0);
        cyc = 0;
        while (sample_valid_strobe !== 1'b1 && cyc < 100) begin
            @(posedge sys_clk);
            #1 cyc++;
        end
        // First sample needs eight ticks, plus divider phase and strobe
        check(32'(cyc >= 16 && cyc <= 22), 32'h1);
        wait_ticks(10);
        check(32'(cap_a), 32'(fmt(13'h0123, 1'b1)));
        final_report();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
endmodule
bind dap_top dap_port_asserts dap_port_asserts_inst (.*);
`default_nettype wire
